/* File: scf_core.sv */
/*
 * Command handler of a telemetry slave: select/operate control towards the
 * host controller, buffer freezes, exception logging and reporting.
 * Assumes commands arrive as one-cycle pulses, one per exchange, and that
 * the host writes live data through the live write port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scf_consts.svh"

// How it works
// - Accepted control goes to host next cycle; no memory changes from control.
// - Operate accepted only directly after matching select or with direct control; otherwise discarded.
// - Direct control input lets an operate act without select.
// - Momentary address is board and point; action value is always one.
// - Continuous address combines board and point.
// - Setpoint address is board as upper seven bits, point as low bit.
// - Setpoint and control values passed to host saturate at 12 bits.
// - Meter and analog freezes act once, only if previous frozen buffer was read.
// - Code 43 freezes meters, 44 analogs, 45 both.
// - Special freeze copies live data into hourly, local, periodic sets.
// - Exception logged only when change exceeds class dead-band.
// - Dead-bands: analog 1000, meter 100, tank 0, status 0.
// - Exception request reports current or all entries by update bit.
// - Code 10 returns frozen analog buffer of up to 250 words.
// - Code 11 returns frozen meter buffer.
module scf_core (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 cmd_valid,
    input  wire scf_pkg::mst_cmd_s    cmd,
    input  wire logic                 direct_ctl,
    output logic                      ctl_valid_q,
    output scf_pkg::ctl_out_s         ctl_q,
    input  wire logic                 live_wr,
    input  wire scf_pkg::data_class_e live_cls,
    input  wire logic [7:0]           live_idx,
    input  wire logic [15:0]          live_data,
    input  wire logic                 rd_valid,
    input  wire scf_pkg::rd_req_s     rd_req,
    output logic                      rd_ack_q,
    output logic [15:0]               rd_data_q,
    output logic                      frz_busy_q,
    output logic                      exc_valid_q,
    output scf_pkg::exc_entry_s       exc_q,
    output logic                      exc_done_q
);

    logic [15:0] live_mem [0:3][0:249];
    logic [15:0] frz_mem  [0:1][0:249];
    logic [15:0] snap_mem [0:5][0:249];
    scf_pkg::exc_entry_s exc_mem [0:15];

    // Control decode
    wire is_sel = cmd_valid && (cmd.code == `FN_MOM_SEL || cmd.code == `FN_CON_SEL
                                || cmd.code == `FN_SET_SEL);
    wire is_op  = cmd_valid && (cmd.code == `FN_MOM_OP || cmd.code == `FN_CON_OP
                                || cmd.code == `FN_SET_OP);
    wire scf_pkg::ctl_kind_e cmd_kind =
        (cmd.code == `FN_MOM_SEL || cmd.code == `FN_MOM_OP) ? scf_pkg::CTL_MOM :
        (cmd.code == `FN_CON_SEL || cmd.code == `FN_CON_OP) ? scf_pkg::CTL_CON :
        scf_pkg::CTL_SET;
    wire [7:0]  cmd_addr = {cmd.board, cmd.point};
    wire [11:0] sat_val  = (cmd.value > {4'h0, `CTL_MAX}) ? `CTL_MAX
                                                           : cmd.value[11:0];

    logic                pend_v_q;
    scf_pkg::ctl_kind_e  pend_kind_q;
    logic [7:0]          pend_addr_q;
    wire sel_match = pend_v_q && pend_kind_q == cmd_kind && pend_addr_q == cmd_addr;
    wire op_take   = is_op && (sel_match || direct_ctl);

    // Any command other than a select ends the select window
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_v_q    <= 1'b0;
            pend_kind_q <= scf_pkg::CTL_MOM;
            pend_addr_q <= 8'h00;
        end else if (cmd_valid) begin
            pend_v_q    <= is_sel;
            pend_kind_q <= cmd_kind;
            pend_addr_q <= cmd_addr;
        end
    end

    // Control only reaches the host, never the data memories
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_valid_q <= 1'b0;
            ctl_q       <= '0;
        end else begin
            ctl_valid_q <= op_take;
            if (op_take) begin
                ctl_q.kind  <= cmd_kind;
                ctl_q.addr  <= cmd_addr;
                ctl_q.value <= (cmd_kind == scf_pkg::CTL_MOM) ? `MOM_ACTION : sat_val;
            end
        end
    end

    // Freeze engine
    scf_pkg::copy_state_e cp_q;
    logic [7:0] cp_idx_q;
    logic       cp_mtr_q;
    logic       cp_ana_q;
    logic       cp_spc_q;
    logic [1:0] rd_done_q;   // Bit 0 analog, bit 1 meter

    wire frz_m = cmd_valid && (cmd.code == `FN_FRZ_MTR || cmd.code == `FN_FRZ_BOTH);
    wire frz_a = cmd_valid && (cmd.code == `FN_FRZ_ANA || cmd.code == `FN_FRZ_BOTH);
    wire frz_s = cmd_valid && cmd.code == `FN_FRZ_SPC;
    wire idle  = cp_q == scf_pkg::CP_IDLE;
    // Freezes during a copy are dropped: the request is a single pulse
    wire go_m  = idle && frz_m && rd_done_q[1];
    wire go_a  = idle && frz_a && rd_done_q[0];
    wire go_s  = idle && frz_s;
    wire rd_a  = rd_valid && rd_req.code == `FN_RD_FRZ_ANA;
    wire rd_m  = rd_valid && rd_req.code == `FN_RD_FRZ_MTR;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cp_q     <= scf_pkg::CP_IDLE;
            cp_idx_q <= 8'h00;
            cp_mtr_q <= 1'b0;
            cp_ana_q <= 1'b0;
            cp_spc_q <= 1'b0;
        end else begin
            unique case (cp_q)
                scf_pkg::CP_IDLE: begin
                    cp_idx_q <= 8'h00;
                    cp_mtr_q <= go_m;
                    cp_ana_q <= go_a;
                    cp_spc_q <= go_s;
                    if (go_m || go_a || go_s) begin
                        cp_q <= scf_pkg::CP_RUN;
                    end
                end
                scf_pkg::CP_RUN: begin
                    cp_idx_q <= cp_idx_q + 8'h01;
                    if (cp_idx_q == `BUF_LAST) begin
                        cp_q <= scf_pkg::CP_IDLE;
                    end
                end
                default: cp_q <= scf_pkg::CP_IDLE;
            endcase
        end
    end

    // Read wins over a freeze in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_done_q  <= `RD_DONE_RST;
            frz_busy_q <= 1'b0;
        end else begin
            rd_done_q[0] <= rd_a || (rd_done_q[0] && !go_a);
            rd_done_q[1] <= rd_m || (rd_done_q[1] && !go_m);
            frz_busy_q   <= (idle && (go_m || go_a || go_s))
                            || (!idle && cp_idx_q != `BUF_LAST);
        end
    end

    wire running = cp_q == scf_pkg::CP_RUN;

    always_ff @(posedge clock) begin
        if (running && cp_ana_q) begin
            frz_mem[0][cp_idx_q] <= live_mem[scf_pkg::CLS_ANALOG][cp_idx_q];
        end
        if (running && cp_mtr_q) begin
            frz_mem[1][cp_idx_q] <= live_mem[scf_pkg::CLS_METER][cp_idx_q];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_snap
            always_ff @(posedge clock) begin
                if (running && cp_spc_q) begin
                    snap_mem[g][cp_idx_q] <= live_mem[g % 2][cp_idx_q];
                end
            end
        end
    endgenerate

    // Master reads of frozen and snapshot buffers
    wire        rd_ok   = rd_req.index < `BUF_WORDS;
    wire [2:0]  snap_i  = {rd_req.sel[2:1], 1'b0} + {2'h0, rd_req.sel[0]};
    wire [15:0] rd_word = !rd_ok ? 16'h0000 :
                          rd_a ? frz_mem[0][rd_req.index] :
                          rd_m ? frz_mem[1][rd_req.index] :
                          (rd_req.code == `FN_RD_SNAP && rd_req.sel[2:1] != 2'h3)
                              ? snap_mem[snap_i][rd_req.index] : 16'h0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_q  <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            rd_ack_q  <= rd_valid;
            rd_data_q <= rd_valid ? rd_word : rd_data_q;
        end
    end

    // Live data and exception detection
    wire [15:0] old_val = live_mem[live_cls][live_idx];
    wire [15:0] mag     = (live_data >= old_val) ? live_data - old_val
                                                 : old_val - live_data;
    wire [15:0] dband   = (live_cls == scf_pkg::CLS_ANALOG) ? `DB_ANALOG :
                          (live_cls == scf_pkg::CLS_METER)  ? `DB_METER  :
                          (live_cls == scf_pkg::CLS_TANK)   ? `DB_TANK   : `DB_STATUS;
    wire        wr_ok   = live_wr && live_idx < `BUF_WORDS;
    wire        exc_log = wr_ok && mag > dband;

    // Status writes from the host are how control outcomes become visible
    always_ff @(posedge clock) begin
        if (wr_ok) begin
            live_mem[live_cls][live_idx] <= live_data;
        end
    end

    logic [3:0] ewp_q;
    logic [4:0] ecnt_q;
    logic [4:0] enew_q;
    scf_pkg::exc_state_e ex_q;
    logic [3:0] erp_q;
    logic [4:0] erem_q;

    always_ff @(posedge clock) begin
        if (exc_log) begin
            exc_mem[ewp_q] <= '{cls: live_cls, index: live_idx, value: live_data};
        end
    end

    wire        exc_req = cmd_valid && cmd.code == `FN_EXC_REQ && ex_q == scf_pkg::EX_IDLE;
    wire [4:0]  exc_n   = cmd.update ? enew_q : ecnt_q;
    wire [3:0]  exc_st  = ewp_q - exc_n[3:0];
    wire [4:0]  new_inc = (enew_q == `EXC_FULL) ? enew_q : enew_q + 5'h01;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ewp_q  <= 4'h0;
            ecnt_q <= 5'h00;
            enew_q <= 5'h00;
        end else begin
            if (exc_log) begin
                ewp_q  <= ewp_q + 4'h1;
                ecnt_q <= (ecnt_q == `EXC_FULL) ? ecnt_q : ecnt_q + 5'h01;
            end
            // A new entry in the clearing cycle still counts as current
            if (exc_req && cmd.update) begin
                enew_q <= {4'h0, exc_log};
            end else if (exc_log) begin
                enew_q <= new_inc;
            end
        end
    end

    // Entries logged while streaming may overtake the oldest ones sent
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ex_q        <= scf_pkg::EX_IDLE;
            erp_q       <= 4'h0;
            erem_q      <= 5'h00;
            exc_valid_q <= 1'b0;
            exc_q       <= '0;
            exc_done_q  <= 1'b0;
        end else begin
            exc_valid_q <= 1'b0;
            exc_done_q  <= 1'b0;
            unique case (ex_q)
                scf_pkg::EX_IDLE: begin
                    if (exc_req) begin
                        erp_q  <= exc_st;
                        erem_q <= exc_n;
                        ex_q   <= (exc_n == 5'h00) ? scf_pkg::EX_DONE : scf_pkg::EX_SEND;
                    end
                end
                scf_pkg::EX_SEND: begin
                    exc_valid_q <= 1'b1;
                    exc_q       <= exc_mem[erp_q];
                    erp_q       <= erp_q + 4'h1;
                    erem_q      <= erem_q - 5'h01;
                    if (erem_q == 5'h01) begin
                        ex_q <= scf_pkg::EX_DONE;
                    end
                end
                scf_pkg::EX_DONE: begin
                    exc_done_q <= 1'b1;
                    ex_q       <= scf_pkg::EX_IDLE;
                end
                default: ex_q <= scf_pkg::EX_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_select;
        is_sel;
    endsequence
    sequence s_bad_op;
        is_op && !direct_ctl && !sel_match;
    endsequence

    a_op_discard: assert property (s_bad_op |=> !ctl_valid_q)
        else $error("operate without matching select was forwarded");
    // Select, one quiet cycle, then the matching operate: the master's usual spacing
    a_sel_then_op: assert property (s_select ##1 !cmd_valid ##1 (is_op
        && cmd_kind == $past(cmd_kind, 2) && cmd_addr == $past(cmd_addr, 2))
        |=> ctl_valid_q && ctl_q.addr == $past(cmd_addr))
        else $error("matching operate after select not forwarded");
    a_direct_op: assert property (is_op && direct_ctl |=> ctl_valid_q)
        else $error("direct operate not forwarded");
    a_mom_action: assert property (ctl_valid_q && ctl_q.kind == scf_pkg::CTL_MOM
        |-> ctl_q.value == `MOM_ACTION)
        else $error("momentary action value not one");
    a_set_limit: assert property (op_take && cmd_kind == scf_pkg::CTL_SET
        && cmd.value[15:12] != 4'h0 |=> ctl_q.value == `CTL_MAX)
        else $error("setpoint not saturated");
    a_frz_gated: assert property (idle && frz_m && !rd_done_q[1] && !frz_a && !frz_s
        |=> cp_q == scf_pkg::CP_IDLE)
        else $error("meter freeze moved unread buffer");
    a_frz_flag: assert property (go_a && !rd_a |=> !rd_done_q[0])
        else $error("analog read flag not cleared by freeze");
    a_copy_len: assert property (go_m |=> running [*8])
        else $error("meter freeze copy ended early");
    a_exc_band: assert property (exc_log |-> mag > dband)
        else $error("exception logged inside dead-band");
    a_exc_done: assert property (exc_req |-> ##[1:18] exc_done_q)
        else $error("exception report did not finish");
    a_rd_answer: assert property (rd_a && rd_ok |=> rd_ack_q && rd_data_q == $past(rd_word))
        else $error("frozen analog read not answered");

endmodule

`default_nettype wire

/* File: scf_consts.svh */
/*
 * Codes, sizes and default dead-bands of the slave command handler.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SCF_CONSTS_SVH
`define SCF_CONSTS_SVH

`define FN_RD_FRZ_ANA  8'h0a
`define FN_RD_FRZ_MTR  8'h0b
`define FN_RD_SNAP     8'h10
`define FN_MOM_SEL     8'h1e
`define FN_MOM_OP      8'h1f
`define FN_CON_SEL     8'h20
`define FN_CON_OP      8'h21
`define FN_SET_SEL     8'h22
`define FN_SET_OP      8'h23
`define FN_FRZ_MTR     8'h2b
`define FN_FRZ_ANA     8'h2c
`define FN_FRZ_BOTH    8'h2d
`define FN_FRZ_SPC     8'h2e
`define FN_EXC_REQ     8'h32

`define BUF_WORDS      8'hfa
`define BUF_LAST       8'hf9
`define CTL_MAX        12'hfff
`define MOM_ACTION     12'h001

`define DB_ANALOG      16'h03e8
`define DB_METER       16'h0064
`define DB_TANK        16'h0000
`define DB_STATUS      16'h0000

`define EXC_FULL       5'h10
`define RD_DONE_RST    2'h3

`endif

/* File: scf_pkg.sv */
/*
 * Types shared by the slave command handler.
 * Assumes scf_consts.svh for all numeric values.
 */
package scf_pkg;

    typedef enum logic [1:0] {
        CLS_ANALOG = 2'h0,
        CLS_METER  = 2'h1,
        CLS_TANK   = 2'h2,
        CLS_STATUS = 2'h3
    } data_class_e;

    typedef enum logic [1:0] {
        CTL_MOM = 2'h0,
        CTL_CON = 2'h1,
        CTL_SET = 2'h2
    } ctl_kind_e;

    typedef enum logic [1:0] {
        CP_IDLE = 2'h0,
        CP_RUN  = 2'h1
    } copy_state_e;

    typedef enum logic [1:0] {
        EX_IDLE = 2'h0,
        EX_SEND = 2'h1,
        EX_DONE = 2'h3
    } exc_state_e;

    typedef struct packed {
        logic [7:0]  code;
        logic [6:0]  board;
        logic        point;
        logic [15:0] value;
        logic        update;
    } mst_cmd_s;

    typedef struct packed {
        ctl_kind_e   kind;
        logic [7:0]  addr;
        logic [11:0] value;
    } ctl_out_s;

    typedef struct packed {
        logic [7:0] code;
        logic [2:0] sel;
        logic [7:0] index;
    } rd_req_s;

    typedef struct packed {
        data_class_e cls;
        logic [7:0]  index;
        logic [15:0] value;
    } exc_entry_s;

endpackage

/* File: scf_master.sv */
/*
 * Polling master station model: sends one command per exchange and reads
 * buffers word by word. Assumes scf_core answers a read one cycle after it.
 */
`timescale 1ns/1ps
`default_nettype none
module scf_master (
    input  wire logic           clock,
    output var scf_pkg::mst_cmd_s cmd,
    output logic                cmd_valid,
    output logic                rd_valid,
    output var scf_pkg::rd_req_s rd_req,
    input  wire logic           rd_ack_q,
    input  wire logic [15:0]    rd_data_q
);
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
        rd_valid  = 1'b0;
        rd_req    = '0;
    end

    // Idle lines show the inverse, so a stale command never looks fresh
    task automatic send(input logic [7:0] code, input logic [7:0] addr,
                        input logic [15:0] value, input logic update);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd       <= {code, addr, value, update};
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd       <= ~{code, addr, value, update};
    endtask

    // Reading a frozen buffer re-arms its freeze
    task automatic read(input logic [7:0] code, input logic [2:0] sel, input logic [7:0] idx,
                        output logic ack, output logic [15:0] data);
        @(posedge clock);
        rd_valid <= 1'b1;
        rd_req   <= {code, sel, idx};
        @(posedge clock);
        rd_valid <= 1'b0;
        rd_req   <= ~{code, sel, idx};
        // The acknowledge stands for one cycle only, so take it now
        #1;
        ack  = rd_ack_q;
        data = rd_data_q;
    endtask
endmodule
`default_nettype wire

/* File: slave_control_freeze_exception_tb.sv */
/*
 * Self-checking bench of scf_core with a master model and a host model.
 * Assumes scf_master drives the command and read ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scf_consts.svh"
module slave_control_freeze_exception_tb;
    logic                 clock, rst_n, direct_ctl, cmd_valid, ctl_valid_q, live_wr;
    logic                 rd_valid, rd_ack_q, frz_busy_q, exc_valid_q, exc_done_q, ack, track;
    scf_pkg::mst_cmd_s    cmd;
    scf_pkg::ctl_out_s    ctl_q;
    scf_pkg::data_class_e live_cls;
    logic [7:0]           live_idx;
    logic [15:0]          live_data, rd_data_q, rd;
    scf_pkg::rd_req_s     rd_req;
    scf_pkg::exc_entry_s  exc_q;
    int                   err_count, tests_run, cyc, seed, fa[250], fm[250], live_m[4][250];
    logic [25:0]          exq[$];
    int                   exv[4][3] = '{'{16'h1000, 16'h13e8, 16'h17d1}, '{16'h0200, 16'h0264,
                                      16'h02c9}, '{5, 5, 6}, '{1, 1, 0}};

    scf_master u_mst (.clock(clock), .cmd(cmd), .cmd_valid(cmd_valid), .rd_valid(rd_valid),
                      .rd_req(rd_req), .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q));
    scf_core u_dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
                    .direct_ctl(direct_ctl), .ctl_valid_q(ctl_valid_q), .ctl_q(ctl_q),
                    .live_wr(live_wr), .live_cls(live_cls), .live_idx(live_idx),
                    .live_data(live_data), .rd_valid(rd_valid), .rd_req(rd_req),
                    .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q), .frz_busy_q(frz_busy_q),
                    .exc_valid_q(exc_valid_q), .exc_q(exc_q), .exc_done_q(exc_done_q));

    initial clock = 1'b0;
    always #20 clock = ~clock;

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic int db(input int c);
        return c == 0 ? 1000 : (c == 1 ? 100 : 0);
    endfunction

    // Host side: live write, with the exception model alongside
    task automatic wr(input int cls, input int idx, input int val);
        int old;
        old = live_m[cls][idx];
        if (track && (val > old ? val - old : old - val) > db(cls))
            exq.push_back({cls[1:0], idx[7:0], val[15:0]});
        live_m[cls][idx] = val;
        @(posedge clock);
        live_wr   <= 1'b1;
        live_cls  <= scf_pkg::data_class_e'(cls[1:0]);
        live_idx  <= idx[7:0];
        live_data <= val[15:0];
        @(posedge clock);
        live_wr   <= 1'b0;
        live_data <= ~val[15:0];
    endtask

    task automatic refill();
        for (int i = 0; i < 250; i++) begin
            wr(0, i, $random(seed) & 16'hffff);
            wr(1, i, $random(seed) & 16'hffff);
        end
    endtask

    task automatic frz(input logic [7:0] code, input logic run);
        int n;
        n = 0;
        u_mst.send(code, 8'h00, 16'h0000, 1'b0);
        #1;
        while (frz_busy_q === 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(n, run ? 250 : 0);
    endtask

    // Index 250 lies past the buffer and must read as zero
    task automatic chk_buf(input logic [7:0] code, input int a[250]);
        for (int i = 0; i < 251; i++) begin
            u_mst.read(code, 3'h0, i[7:0], ack, rd);
            chk(ack, 1);
            chk(rd, i < 250 ? a[i] : 0);
        end
    endtask

    task automatic op_chk(input logic v, input logic [21:0] exp);
        #1;
        chk(ctl_valid_q, v);
        if (v)
            chk(ctl_q, exp);
        @(posedge clock);
        #1;
        chk(ctl_valid_q, 0);
    endtask

    // A negative count only drains the report
    task automatic exc_rep(input logic upd, input int exp_n);
        int n, d;
        n = 0;
        d = 0;
        u_mst.send(`FN_EXC_REQ, 8'h00, 16'h0000, upd);
        for (int c = 1; c < 40 && d == 0; c++) begin
            @(posedge clock);
            #1;
            if (exc_valid_q === 1'b1) begin
                n++;
                if (exq.size() > 0)
                    chk(exc_q, exq.pop_front());
            end
            if (exc_done_q === 1'b1)
                d = c;
        end
        if (exp_n >= 0) begin
            chk(n, exp_n);
            chk(d, exp_n + 1);
        end
    endtask

    initial begin
        int k, a, v;
        seed = 32'h0e44;
        {rst_n, direct_ctl, live_wr, live_idx, live_data, track} = '0;
        live_cls = scf_pkg::CLS_ANALOG;
        {err_count, tests_run, cyc} = '0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        refill();
        frz(`FN_FRZ_BOTH, 1'b1);
        fa = live_m[0];
        fm = live_m[1];
        chk_buf(`FN_RD_FRZ_ANA, fa);
        chk_buf(`FN_RD_FRZ_MTR, fm);
        refill();
        frz(`FN_FRZ_ANA, 1'b1);
        fa = live_m[0];
        frz(`FN_FRZ_ANA, 1'b0);
        frz(`FN_FRZ_MTR, 1'b1);
        fm = live_m[1];
        refill();
        frz(`FN_FRZ_MTR, 1'b0);
        frz(`FN_FRZ_SPC, 1'b1);
        for (int s = 0; s < 6; s++)
            for (int i = 0; i < 250; i += 249) begin
                u_mst.read(`FN_RD_SNAP, s[2:0], i[7:0], ack, rd);
                chk(rd, live_m[s % 2][i]);
            end
        chk_buf(`FN_RD_FRZ_ANA, fa);
        chk_buf(`FN_RD_FRZ_MTR, fm);
        exc_rep(1'b1, -1);
        for (int c = 0; c < 4; c++)
            wr(c, 7, exv[c][0]);
        exc_rep(1'b1, -1);
        track = 1'b1;
        for (int st = 1; st < 3; st++)
            for (int c = 0; c < 4; c++)
                wr(c, 7, exv[c][st]);
        exc_rep(1'b1, 4);
        exc_rep(1'b1, 0);
        exc_rep(1'b0, 16);
        track = 1'b0;
        // Upper half of the sweep keeps values below the saturation point
        for (int j = 0; j < 6; j++) begin
            k = j % 3;
            a = $random(seed) & 8'hff;
            v = $random(seed) & (j < 3 ? 16'hffff : 16'h0fff);
            u_mst.send(8'(`FN_MOM_SEL + 2 * k), a[7:0], v[15:0], 1'b0);
            u_mst.send(8'(`FN_MOM_OP + 2 * k), a[7:0], v[15:0], 1'b0);
            op_chk(1'b1, {k[1:0], a[7:0], k == 0 ? `MOM_ACTION :
                   (v > 4095 ? `CTL_MAX : v[11:0])});
        end
        u_mst.send(`FN_CON_SEL, 8'h12, 16'h0005, 1'b0);
        u_mst.send(`FN_CON_OP, 8'h13, 16'h0005, 1'b0);
        op_chk(1'b0, '0);
        u_mst.send(`FN_SET_SEL, 8'h12, 16'h0005, 1'b0);
        u_mst.send(8'h01, 8'h00, 16'h0000, 1'b0);
        u_mst.send(`FN_SET_OP, 8'h12, 16'h0005, 1'b0);
        op_chk(1'b0, '0);
        u_mst.send(`FN_MOM_OP, 8'h21, 16'h0000, 1'b0);
        op_chk(1'b0, '0);
        @(posedge clock);
        direct_ctl <= 1'b1;
        u_mst.send(`FN_MOM_OP, 8'h21, 16'h0000, 1'b0);
        op_chk(1'b1, {2'h0, 8'h21, `MOM_ACTION});
        wr(3, 8'h21, 1);
        u_mst.read(`FN_RD_FRZ_ANA, 3'h0, 8'h00, ack, rd);
        chk(rd, fa[0]);
        give_verdict();
    end
endmodule
`default_nettype wire
